// ### src/lbm_params.svh
/*
  Offsets, field positions, reset values and fixed limits of the line
  error rate monitor. Assumes inclusion by the package and by the top.
*/
`ifndef LBM_PARAMS_SVH
`define LBM_PARAMS_SVH

// byte offsets inside one monitor instance
`define LBM_OFF_CFG        5'h00
`define LBM_OFF_PERIOD     5'h04
`define LBM_OFF_DECL_THR   5'h08
`define LBM_OFF_CLR_THR    5'h0C
`define LBM_OFF_SAT_THR    5'h10
// shared registers
`define LBM_OFF_STATUS     8'h40
`define LBM_OFF_EVENT      8'h44
`define LBM_OFF_IRQ_EN     8'h48

// cfg register fields
`define LBM_CFG_CLR_MODE_BIT  0
`define LBM_CFG_SAT_MODE_BIT  1

// reset values
`define LBM_RST_PERIOD     24'h000008
`define LBM_RST_DECL_THR   12'hFFF
`define LBM_RST_CLR_THR    12'h000
`define LBM_RST_SAT_THR    12'hFFF

// saturation value and clear window stretch (x8)
`define LBM_CNT_MAX        12'hFFF
`define LBM_CLR_WIN_SHIFT  3

`endif

// ### src/lbm_pkg.sv
/*
  Types shared by the error rate monitor files.
  Assumes lbm_params.svh sits beside it on the include path.
*/
`include "lbm_params.svh"

package lbm_pkg;

  typedef struct packed {
    logic        clear_window_mode;
    logic        saturation_mode;
    logic [23:0] accumulation_period;
    logic [11:0] declaration_threshold;
    logic [11:0] clearing_threshold;
    logic [11:0] saturation_threshold;
  } lbm_cfg_t;

  typedef struct packed {
    logic       vld;
    logic [7:0] cnt;
  } lbm_err_t;

  typedef enum logic [1:0] {
    LBM_ST_DECLARE = 2'b01,
    LBM_ST_CLEAR   = 2'b10
  } lbm_state_t;

endpackage

// ### src/lbm_rate_unit.sv
/*
  One error rate monitor: accumulates line parity errors over a window of
  sub-period ticks, declares or clears its alarm against thresholds.
  Assumes tick and err are synchronous to clk, tick one cycle wide.
*/
`timescale 1ns/100ps
`default_nettype none

module lbm_rate_unit
  import lbm_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  var  lbm_cfg_t cfg,
  input  wire logic tick,
  input  var  lbm_err_t err,
  output logic      alarm,
  output logic      event_p
);

  lbm_state_t  state_r,    state_nxt;
  logic [11:0] tick_err_r, tick_err_nxt;
  logic [11:0] acc_r,      acc_nxt;
  logic [26:0] win_cnt_r,  win_cnt_nxt;
  logic        alarm_r,    alarm_nxt;
  logic        event_r,    event_nxt;
  logic [12:0] tick_sum;
  logic [11:0] tick_tot;
  logic [11:0] contrib;
  logic [12:0] acc_sum;
  logic [11:0] acc_tot;
  logic [26:0] win_len;
  logic        win_end;

  always_comb begin
    tick_sum = {1'b0, tick_err_r} + {5'h00, (err.vld ? err.cnt : 8'h00)};
    tick_tot = tick_sum[12] ? `LBM_CNT_MAX : tick_sum[11:0];
    // per-tick cap limits bursts; 0xFFF never bites
    contrib = (cfg.saturation_mode && tick_tot > cfg.saturation_threshold) ?
              cfg.saturation_threshold : tick_tot;
    acc_sum = {1'b0, acc_r} + {1'b0, contrib};
    acc_tot = acc_sum[12] ? `LBM_CNT_MAX : acc_sum[11:0];
    if (!cfg.saturation_mode && acc_tot > cfg.saturation_threshold) begin
      acc_tot = cfg.saturation_threshold;
    end
    // clearing window stretched by eight when selected
    if (state_r == LBM_ST_CLEAR && cfg.clear_window_mode) begin
      win_len = {cfg.accumulation_period, 3'b000};
    end else begin
      win_len = {3'b000, cfg.accumulation_period};
    end
    // period of zero behaves as one tick
    win_end = tick && ((win_cnt_r + 27'h1) >= win_len);
    tick_err_nxt = tick ? 12'h000 : tick_tot;
    acc_nxt      = tick ? acc_tot : acc_r;
    win_cnt_nxt  = tick ? win_cnt_r + 27'h1 : win_cnt_r;
    state_nxt    = state_r;
    event_nxt    = 1'b0;
    if (win_end) begin
      acc_nxt     = 12'h000;
      win_cnt_nxt = 27'h0;
      case (state_r)
        LBM_ST_DECLARE: begin
          if (acc_tot >= cfg.declaration_threshold) begin
            state_nxt = LBM_ST_CLEAR;
            event_nxt = 1'b1;
          end
        end
        LBM_ST_CLEAR: begin
          if (acc_tot < cfg.clearing_threshold) begin
            state_nxt = LBM_ST_DECLARE;
            event_nxt = 1'b1;
          end
        end
        default: begin
          state_nxt = LBM_ST_DECLARE;
        end
      endcase
    end
    alarm_nxt = (state_nxt == LBM_ST_CLEAR);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r    <= LBM_ST_DECLARE;
      tick_err_r <= 12'h000;
      acc_r      <= 12'h000;
      win_cnt_r  <= 27'h0;
      alarm_r    <= 1'b0;
      event_r    <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      tick_err_r <= tick_err_nxt;
      acc_r      <= acc_nxt;
      win_cnt_r  <= win_cnt_nxt;
      alarm_r    <= alarm_nxt;
      event_r    <= event_nxt;
    end
  end

  assign alarm   = alarm_r;
  assign event_p = event_r;

  chk_declare_on_thr: assert property (@(posedge clk) disable iff (!rst_n)
    win_end && state_r == LBM_ST_DECLARE && acc_tot >= cfg.declaration_threshold
    |=> alarm_r && event_r)
    else $error("alarm not declared at threshold");

  chk_clear_on_thr: assert property (@(posedge clk) disable iff (!rst_n)
    win_end && state_r == LBM_ST_CLEAR && acc_tot < cfg.clearing_threshold
    |=> !alarm_r && event_r)
    else $error("alarm not cleared below threshold");

  chk_window_restart: assert property (@(posedge clk) disable iff (!rst_n)
    win_end |=> acc_r == 12'h000 && win_cnt_r == 27'h0)
    else $error("count not restarted at window end");

  chk_event_change: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 (alarm_r != $past(alarm_r)) == event_r)
    else $error("event pulse does not match alarm change");

  chk_clear_window_len: assert property (@(posedge clk) disable iff (!rst_n)
    win_end && state_r == LBM_ST_CLEAR && cfg.clear_window_mode &&
    cfg.accumulation_period != 24'h0
    |-> win_cnt_r + 27'h1 == {cfg.accumulation_period, 3'b000})
    else $error("clear window not eight periods");

  chk_acc_capped: assert property (@(posedge clk) disable iff (!rst_n)
    !cfg.saturation_mode && $stable(cfg) |=> acc_r <= cfg.saturation_threshold)
    else $error("window count above saturation");

  cov_declare: cover property (@(posedge clk) disable iff (!rst_n) $rose(alarm_r));
  cov_clear: cover property (@(posedge clk) disable iff (!rst_n) $fell(alarm_r));
  cov_long_clear: cover property (@(posedge clk) disable iff (!rst_n)
    win_end && state_r == LBM_ST_CLEAR && cfg.clear_window_mode);

endmodule

`default_nettype wire

// ### src/lbm_top.sv
/*
  Line error rate monitor top: two monitors (degrade and fail) with a
  classic Wishbone slave for settings, status, sticky events, irq enable.
  Assumes all inputs synchronous to SYS_CLK; LINE_TICK marks sub-periods.
*/
// Local design decisions: the Wishbone register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "lbm_params.svh"

// What this block does
// - two independent monitors, one for signal degrade, one for signal fail.
// - each monitor counts line parity errors over a programmed accumulation period.
// - alarm off evaluates for declaring; alarm on evaluates for clearing.
// - separate declaration and clearing thresholds, one shared accumulation period, all programmable.
// - clear window mode one makes clearing window eight declaration windows.
// - clear window mode zero makes clearing window equal declaration window.
// - saturation threshold defaults all ones, which means no saturation.
// - both monitors identical, same settings, differ only by programmed rate.
module lbm_top
  import lbm_pkg::*;
(
  input  wire logic        SYS_CLK,
  input  wire logic        RST_N,
  input  wire logic        LINE_TICK,
  input  wire logic        BIP_ERR_VLD,
  input  wire logic [7:0]  BIP_ERR_CNT,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic             WB_ACK_O,
  output logic [31:0]      WB_DAT_O,
  output logic             SIGNAL_DEGRADE_ALARM,
  output logic             SIGNAL_FAIL_ALARM,
  output logic             IRQ
);

  lbm_cfg_t    cfg_r [2];
  lbm_cfg_t    cfg_nxt [2];
  logic [1:0]  event_r,  event_nxt;
  logic [1:0]  irq_en_r, irq_en_nxt;
  logic        ack_r,    ack_nxt;
  logic [31:0] rdat_r,   rdat_nxt;
  logic        irq_r,    irq_nxt;
  logic [1:0]  alarm;
  logic [1:0]  ev_pulse;
  logic        req;
  logic        wr;
  logic        inst_hit;
  logic        inst_sel;
  logic [31:0] wmask;
  lbm_err_t    err;

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [31:0] m);
    merge = (old_v & ~m) | (new_v & m);
  endfunction

  assign err = '{vld: BIP_ERR_VLD, cnt: BIP_ERR_CNT};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_mon
      lbm_rate_unit u_mon (
        .clk     (SYS_CLK),
        .rst_n   (RST_N),
        .cfg     (cfg_r[gi]),
        .tick    (LINE_TICK),
        .err     (err),
        .alarm   (alarm[gi]),
        .event_p (ev_pulse[gi])
      );
    end
  endgenerate

  assign SIGNAL_DEGRADE_ALARM = alarm[0];
  assign SIGNAL_FAIL_ALARM    = alarm[1];

  // request decode; ack comes one cycle after the request, writes land on
  // the ack edge so the master and slave agree on when it took effect
  always_comb begin
    req      = WB_CYC_I && WB_STB_I;
    wr       = req && WB_WE_I && ack_r;
    inst_hit = (WB_ADR_I[7:6] == 2'b00) && (WB_ADR_I[4:0] <= `LBM_OFF_SAT_THR)
               && (WB_ADR_I[1:0] == 2'b00);
    inst_sel = WB_ADR_I[5];
    wmask    = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}}, {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
    ack_nxt  = req && !ack_r;
  end

  // settings registers
  always_comb begin
    logic [31:0] img;
    img = 32'h0;
    for (int i = 0; i < 2; i++) begin
      cfg_nxt[i] = cfg_r[i];
      if (wr && inst_hit && inst_sel == i[0]) begin
        case (WB_ADR_I[4:0])
          `LBM_OFF_CFG: begin
            img = merge({30'h0, cfg_r[i].saturation_mode, cfg_r[i].clear_window_mode},
                        WB_DAT_I, wmask);
            cfg_nxt[i].clear_window_mode = img[`LBM_CFG_CLR_MODE_BIT];
            cfg_nxt[i].saturation_mode   = img[`LBM_CFG_SAT_MODE_BIT];
          end
          `LBM_OFF_PERIOD: begin
            img = merge({8'h00, cfg_r[i].accumulation_period}, WB_DAT_I, wmask);
            cfg_nxt[i].accumulation_period = img[23:0];
          end
          `LBM_OFF_DECL_THR: begin
            img = merge({20'h0, cfg_r[i].declaration_threshold}, WB_DAT_I, wmask);
            cfg_nxt[i].declaration_threshold = img[11:0];
          end
          `LBM_OFF_CLR_THR: begin
            img = merge({20'h0, cfg_r[i].clearing_threshold}, WB_DAT_I, wmask);
            cfg_nxt[i].clearing_threshold = img[11:0];
          end
          `LBM_OFF_SAT_THR: begin
            img = merge({20'h0, cfg_r[i].saturation_threshold}, WB_DAT_I, wmask);
            cfg_nxt[i].saturation_threshold = img[11:0];
          end
          default: begin
            cfg_nxt[i] = cfg_r[i];
          end
        endcase
      end
    end
  end

  // sticky events: a new change in the clearing cycle survives
  always_comb begin
    event_nxt  = event_r;
    irq_en_nxt = irq_en_r;
    if (wr && WB_ADR_I == `LBM_OFF_EVENT && WB_SEL_I[0]) begin
      event_nxt = event_r & ~WB_DAT_I[1:0];
    end
    if (wr && WB_ADR_I == `LBM_OFF_IRQ_EN && WB_SEL_I[0]) begin
      irq_en_nxt = WB_DAT_I[1:0];
    end
    event_nxt = event_nxt | ev_pulse;
    irq_nxt   = |(event_nxt & irq_en_nxt);
  end

  // read data captured with the ack; unmapped reads return zero
  always_comb begin
    rdat_nxt = rdat_r;
    if (req && !ack_r) begin
      rdat_nxt = 32'h0;
      if (inst_hit) begin
        case (WB_ADR_I[4:0])
          `LBM_OFF_CFG:      rdat_nxt = {30'h0, cfg_r[inst_sel].saturation_mode,
                                         cfg_r[inst_sel].clear_window_mode};
          `LBM_OFF_PERIOD:   rdat_nxt = {8'h00, cfg_r[inst_sel].accumulation_period};
          `LBM_OFF_DECL_THR: rdat_nxt = {20'h0, cfg_r[inst_sel].declaration_threshold};
          `LBM_OFF_CLR_THR:  rdat_nxt = {20'h0, cfg_r[inst_sel].clearing_threshold};
          `LBM_OFF_SAT_THR:  rdat_nxt = {20'h0, cfg_r[inst_sel].saturation_threshold};
          default:           rdat_nxt = 32'h0;
        endcase
      end else begin
        case (WB_ADR_I)
          `LBM_OFF_STATUS: rdat_nxt = {30'h0, alarm};
          `LBM_OFF_EVENT:  rdat_nxt = {30'h0, event_r};
          `LBM_OFF_IRQ_EN: rdat_nxt = {30'h0, irq_en_r};
          default:         rdat_nxt = 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int i = 0; i < 2; i++) begin
        cfg_r[i] <= '{clear_window_mode: 1'b0, saturation_mode: 1'b0,
                      accumulation_period: `LBM_RST_PERIOD,
                      declaration_threshold: `LBM_RST_DECL_THR,
                      clearing_threshold: `LBM_RST_CLR_THR,
                      saturation_threshold: `LBM_RST_SAT_THR};
      end
      event_r  <= 2'h0;
      irq_en_r <= 2'h0;
      ack_r    <= 1'b0;
      rdat_r   <= 32'h0;
      irq_r    <= 1'b0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        cfg_r[i] <= cfg_nxt[i];
      end
      event_r  <= event_nxt;
      irq_en_r <= irq_en_nxt;
      ack_r    <= ack_nxt;
      rdat_r   <= rdat_nxt;
      irq_r    <= irq_nxt;
    end
  end

  assign WB_ACK_O = ack_r;
  assign WB_DAT_O = rdat_r;
  assign IRQ      = irq_r;

  chk_ack_single: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    ack_r |=> !ack_r)
    else $error("ack held longer than one cycle");

  chk_ack_latency: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    req && !ack_r |=> ack_r)
    else $error("ack not given one cycle after request");

  chk_event_sticky: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    ev_pulse[0] |=> event_r[0] [*2])
    else $error("degrade event not held");

  chk_irq_gating: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    ##1 IRQ == |(event_r & irq_en_r))
    else $error("interrupt does not follow enabled events");

  chk_status_read: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    req && !ack_r && !WB_WE_I && WB_ADR_I == `LBM_OFF_STATUS
    |=> WB_DAT_O[1:0] == $past(alarm))
    else $error("status read does not show alarms");

  cov_irq: cover property (@(posedge SYS_CLK) disable iff (!RST_N) $rose(IRQ));
  cov_both_alarms: cover property (@(posedge SYS_CLK) disable iff (!RST_N) &alarm);

endmodule

`default_nettype wire

// ### testbench/lbm_line_model.sv
/*
  Far side model: receive line overhead logic reporting parity errors.
  Assumes one clock; tick every 4 cycles, errors once per sub-period.
*/
`timescale 1ns/100ps
`default_nettype none

module lbm_line_model (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] err_per_tick,
  output logic            tick,
  output logic            err_vld,
  output logic [7:0]      err_cnt
);
  logic [1:0] ph_r;
  logic       rep;

  assign rep = (ph_r == 2'h1) && (err_per_tick != 8'h00);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_r    <= 2'h0;
      tick    <= 1'b0;
      err_vld <= 1'b0;
      err_cnt <= 8'hA5;
    end else begin
      ph_r    <= ph_r + 2'h1;
      tick    <= (ph_r == 2'h3);
      err_vld <= rep;
      // idle count toggles so stale values never look valid
      err_cnt <= rep ? err_per_tick : ~err_cnt;
    end
  end
endmodule
`default_nettype wire

// ### testbench/lbm_top_tb.sv
/*
  Testbench of the error rate monitor top: Wishbone register tasks,
  alarm and event scenarios. Assumes lbm_line_model drives the line side.
*/
`timescale 1ns/100ps
`default_nettype none

module lbm_top_tb;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cyc = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [7:0]  epc = 8'h00;
  logic        tick, vld, ack, sd, sf, irq;
  logic [7:0]  cnt;
  logic [31:0] rdat, rd;
  int          err_total = 0;
  int          checks_done = 0;
  int          cyc_cnt = 0;

  initial forever #12.5 clk = ~clk;

  lbm_line_model i_line (.clk(clk), .rst_n(rst_n), .err_per_tick(epc),
    .tick(tick), .err_vld(vld), .err_cnt(cnt));

  lbm_top i_dut (.SYS_CLK(clk), .RST_N(rst_n), .LINE_TICK(tick),
    .BIP_ERR_VLD(vld), .BIP_ERR_CNT(cnt), .WB_CYC_I(cyc), .WB_STB_I(cyc),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wdat),
    .WB_ACK_O(ack), .WB_DAT_O(rdat), .SIGNAL_DEGRADE_ALARM(sd),
    .SIGNAL_FAIL_ALARM(sf), .IRQ(irq));

  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 6000) begin
      err_total = err_total + 1;
      wrap_up();
    end
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // classic cycle: hold until ack sampled high, then release
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    check(nm, rd, e);
  endtask

  // bounded wait for an alarm level; fail reported through check
  task automatic wait_alarm(input bit fail, input logic v, input int max);
    int n;
    n = 0;
    while (((fail ? sf : sd) !== v) && n < max) begin
      @(negedge clk);
      n++;
    end
    check(fail ? "fail_alarm" : "degrade_alarm", {31'h0, fail ? sf : sd}, {31'h0, v});
  endtask

  task automatic t_reset_values();
    for (int m = 0; m < 2; m++) begin
      rd_chk("cfg", 8'(m * 32), 32'h0);
      rd_chk("period", 8'(m * 32 + 4), 32'h8);
      rd_chk("decl_thr", 8'(m * 32 + 8), 32'hFFF);
      rd_chk("clr_thr", 8'(m * 32 + 12), 32'h0);
      rd_chk("sat_thr", 8'(m * 32 + 16), 32'hFFF);
    end
    rd_chk("unmapped", 8'h7C, 32'h0);
  endtask

  task automatic t_declare();
    wb(1'b1, 8'h04, 32'h2);
    wb(1'b1, 8'h08, 32'h4);
    wb(1'b1, 8'h0C, 32'h1);
    wb(1'b1, 8'h48, 32'h3);
    epc <= 8'h01;
    repeat (64) @(negedge clk);
    check("no_declare_low_rate", {31'h0, sd}, 32'h0);
    epc <= 8'h02;
    wait_alarm(1'b0, 1'b1, 40);
    check("fail_unaffected", {31'h0, sf}, 32'h0);
    repeat (2) @(negedge clk);
    rd_chk("status", 8'h40, 32'h1);
    rd_chk("event", 8'h44, 32'h1);
    check("irq_set", {31'h0, irq}, 32'h1);
    wb(1'b1, 8'h44, 32'h1);
    repeat (2) @(negedge clk);
    rd_chk("event_cleared", 8'h44, 32'h0);
    check("irq_clear", {31'h0, irq}, 32'h0);
  endtask

  task automatic t_clear_equal();
    epc <= 8'h00;
    wait_alarm(1'b0, 1'b0, 24);
    repeat (2) @(negedge clk);
    rd_chk("event_on_clear", 8'h44, 32'h1);
    wb(1'b1, 8'h44, 32'h1);
  endtask

  task automatic t_clear_long();
    wb(1'b1, 8'h00, 32'h1);
    epc <= 8'h02;
    wait_alarm(1'b0, 1'b1, 40);
    epc <= 8'h00;
    repeat (40) @(negedge clk);
    check("still_declared", {31'h0, sd}, 32'h1);
    wait_alarm(1'b0, 1'b0, 60);
  endtask

  task automatic t_saturation();
    wb(1'b1, 8'h24, 32'h2);
    wb(1'b1, 8'h28, 32'h3);
    wb(1'b1, 8'h30, 32'h2);
    epc <= 8'h02;
    repeat (48) @(negedge clk);
    check("sat_blocks", {31'h0, sf}, 32'h0);
    wb(1'b1, 8'h30, 32'hFFF);
    wait_alarm(1'b1, 1'b1, 40);
    rd_chk("status_fail", 8'h40, 32'h3);
    // per-tick cap at 2 keeps a 4-count window above a clear threshold of 3
    wb(1'b1, 8'h20, 32'h2);
    wb(1'b1, 8'h2C, 32'h3);
    wb(1'b1, 8'h30, 32'h2);
    repeat (48) @(negedge clk);
    check("tick_cap_holds", {31'h0, sf}, 32'h1);
    wb(1'b1, 8'h30, 32'h1);
    wait_alarm(1'b1, 1'b0, 40);
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_reset_values();
    t_declare();
    t_clear_equal();
    t_clear_long();
    t_saturation();
    wrap_up();
  end
endmodule
`default_nettype wire
